// ### design/buffer_powerup_output_gating.sv
// Power-up and power-down output gating for a differential clock buffer
// Summary of operation
// - Supply detected starts 0.2-0.3 ms settling
// - Then wait for valid clock, sleep released
// - Enable needs clock, power, wake, lock/mirror
// - Power-up past 1 ms with a valid clock raises budget_exceeded
// - No input clock keeps outputs disabled
// - Bypass mode waives the lock condition
`timescale 1ns/100ps
`default_nettype none
module buffer_powerup_output_gating #(
    parameter int unsigned NUM_PAIRS     = pwrup_seq_pkg::NUM_PAIRS,
    parameter int unsigned SETTLE_CYCLES = pwrup_seq_pkg::SETTLE_CYCLES,
    parameter int unsigned BUDGET_CYCLES = pwrup_seq_pkg::BUDGET_CYCLES
) (
    input  wire logic                 clk_sys,
    input  wire logic                 rstn,
    input  wire logic                 supply_detected,
    input  wire logic                 sleep_request,
    input  wire logic                 reference_input,
    input  wire logic                 pll_locked,
    input  wire logic                 mirror_stable,
    input  wire logic                 bypass_mode,
    output logic                      outputs_active,
    output logic                      budget_exceeded,
    output logic [NUM_PAIRS-1:0]      buffered_output_true_oe_n,
    output logic [NUM_PAIRS-1:0]      buffered_output_complement_oe_n
);
    logic [1:0] rst_sync_q;
    wire        rst_n = rst_sync_q[1];

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    // Clock detect: reference sampled as a synchronous input
    logic        ref_q;
    logic [6:0]  win_cnt_q;
    logic [6:0]  edge_cnt_q;
    logic        clk_valid_q;
    wire         ref_rise   = reference_input & ~ref_q;
    wire         win_end    = (win_cnt_q == 7'(pwrup_seq_pkg::DETECT_WINDOW - 1));
    wire         win_ok     = (edge_cnt_q >= 7'(pwrup_seq_pkg::DETECT_MIN_EDGES));

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ref_q       <= 1'b0;
            win_cnt_q   <= 7'h00;
            edge_cnt_q  <= 7'h00;
            clk_valid_q <= 1'b0;
        end
        else
        begin
            ref_q     <= reference_input;
            win_cnt_q <= win_end ? 7'h00 : win_cnt_q + 7'h01;
            if (win_end)
            begin
                clk_valid_q <= win_ok;
                edge_cnt_q  <= 7'h00;
            end
            else if (ref_rise && !win_ok)
                edge_cnt_q <= edge_cnt_q + 7'h01;
        end
    end

    // Sequencer
    pwrup_seq_pkg::seq_state_t state_q;
    pwrup_seq_pkg::seq_state_t state_d;
    logic [31:0] settle_cnt_q;
    logic [31:0] budget_cnt_q;
    wire         settle_done = (settle_cnt_q >= SETTLE_CYCLES - 1);
    wire         lock_ok     = mirror_stable | pll_locked | bypass_mode;
    wire         wake_ok     = clk_valid_q & ~sleep_request;
    wire         enable_ok   = wake_ok & supply_detected & lock_ok;
    // Sleep floats pairs at once, not waiting for the state to settle
    wire         drive_en    = (state_d == pwrup_seq_pkg::ST_ACTIVE) & ~sleep_request;
    wire         settle_run  = (state_q == pwrup_seq_pkg::ST_SETTLE);
    wire         in_off      = (state_q == pwrup_seq_pkg::ST_OFF);
    logic        was_active_q;
    logic        budget_exceeded_q;
    wire         budget_run  = ~in_off & ~was_active_q & ~drive_en;
    wire         budget_hit  = budget_run & clk_valid_q & (budget_cnt_q >= BUDGET_CYCLES - 1);
    wire  [31:0] budget_cnt_d = in_off ? 32'h0 :
                                (budget_run && budget_cnt_q < BUDGET_CYCLES) ? budget_cnt_q + 32'h1 : budget_cnt_q;

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            pwrup_seq_pkg::ST_OFF:
                if (supply_detected)
                    state_d = pwrup_seq_pkg::ST_SETTLE;
            pwrup_seq_pkg::ST_SETTLE:
                if (!supply_detected)
                    state_d = pwrup_seq_pkg::ST_OFF;
                else if (settle_done)
                    state_d = pwrup_seq_pkg::ST_WAIT;
            pwrup_seq_pkg::ST_WAIT:
                if (!supply_detected)
                    state_d = pwrup_seq_pkg::ST_OFF;
                else if (enable_ok)
                    state_d = pwrup_seq_pkg::ST_ACTIVE;
            pwrup_seq_pkg::ST_ACTIVE:
                if (!supply_detected)
                    state_d = pwrup_seq_pkg::ST_OFF;
                else if (!enable_ok)
                    state_d = pwrup_seq_pkg::ST_WAIT;
            default:
                state_d = pwrup_seq_pkg::ST_OFF;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q      <= pwrup_seq_pkg::ST_OFF;
            settle_cnt_q <= 32'h0;
        end
        else
        begin
            state_q      <= state_d;
            settle_cnt_q <= settle_run ? settle_cnt_q + 32'h1 : 32'h0;
        end
    end

    // Budget covers only the first power-up after OFF, so a long sleep later never raises it
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            budget_cnt_q      <= 32'h0;
            was_active_q      <= 1'b0;
            budget_exceeded_q <= 1'b0;
        end
        else
        begin
            budget_cnt_q      <= budget_cnt_d;
            was_active_q      <= ~in_off & (was_active_q | drive_en);
            budget_exceeded_q <= budget_hit | (~in_off & budget_exceeded_q);
        end
    end

    // Pairs are registered from the next state, so they switch on the edge the state does
    logic                 outputs_active_q;
    logic [NUM_PAIRS-1:0] true_oe_n_q;
    logic [NUM_PAIRS-1:0] comp_oe_n_q;
    wire  [NUM_PAIRS-1:0] oe_n_d = {NUM_PAIRS{~drive_en}};

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            outputs_active_q <= 1'b0;
            true_oe_n_q      <= {NUM_PAIRS{1'b1}};
            comp_oe_n_q      <= {NUM_PAIRS{1'b1}};
        end
        else
        begin
            outputs_active_q <= drive_en;
            true_oe_n_q      <= oe_n_d;
            comp_oe_n_q      <= oe_n_d;
        end
    end

    assign outputs_active                  = outputs_active_q;
    assign budget_exceeded                 = budget_exceeded_q;
    assign buffered_output_true_oe_n       = true_oe_n_q;
    assign buffered_output_complement_oe_n = comp_oe_n_q;

    sequence s_settle_entry;
        state_q == pwrup_seq_pkg::ST_OFF && supply_detected;
    endsequence

    AST_SLEEP_FLOATS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sleep_request |=> &buffered_output_true_oe_n && &buffered_output_complement_oe_n)
        else $error("pairs driven during sleep");
    AST_SETTLE_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_settle_entry |=> state_q == pwrup_seq_pkg::ST_SETTLE)
        else $error("settling not started");
    AST_SETTLE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == pwrup_seq_pkg::ST_WAIT && $past(state_q) == pwrup_seq_pkg::ST_SETTLE
        |-> $past(settle_cnt_q) >= SETTLE_CYCLES - 1)
        else $error("settling cut short");
    AST_WAIT_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == pwrup_seq_pkg::ST_WAIT && !wake_ok |=> state_q != pwrup_seq_pkg::ST_ACTIVE)
        else $error("left wait without clock");
    AST_ENABLE_COND: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(outputs_active) |-> $past(enable_ok))
        else $error("enabled without conditions");
    AST_NO_CLOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !clk_valid_q |=> !outputs_active)
        else $error("active without clock");
    AST_BYPASS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        state_q == pwrup_seq_pkg::ST_WAIT && wake_ok && supply_detected && bypass_mode
        |=> outputs_active)
        else $error("bypass still waits for lock");
    AST_CLK_DROP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        win_end && !win_ok |=> !clk_valid_q)
        else $error("validity kept without edges");
    AST_BUDGET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        outputs_active |-> !budget_exceeded || $past(budget_exceeded))
        else $error("budget flag raised while active");
    AST_BUDGET_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
        budget_run && clk_valid_q && budget_cnt_q >= BUDGET_CYCLES - 1 |=> budget_exceeded)
        else $error("late power-up not flagged");
    AST_SETTLE_MAX: assert property (@(posedge clk_sys) disable iff (!rst_n)
        settle_run |-> settle_cnt_q < pwrup_seq_pkg::SETTLE_MAX_US * pwrup_seq_pkg::CLK_SYS_MHZ)
        else $error("settling overran its window");
    AST_SUPPLY_LOSS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !supply_detected |=> !outputs_active)
        else $error("active without supply");
    AST_NEEDS_LOCK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !lock_ok |=> !outputs_active)
        else $error("active without lock or mirror");
    AST_PAIRS_MATCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        buffered_output_complement_oe_n == buffered_output_true_oe_n
        && buffered_output_true_oe_n == {NUM_PAIRS{!outputs_active}})
        else $error("pair legs disagree");

    sequence s_wake_ready;
        state_q == pwrup_seq_pkg::ST_WAIT && wake_ok && supply_detected;
    endsequence

    AST_WAKE_UP: assert property (@(posedge clk_sys) disable iff (!rst_n)
        s_wake_ready ##0 lock_ok |=> outputs_active)
        else $error("ready but not enabled");
endmodule
`default_nettype wire

// ### design/pwrup_seq_pkg.sv
// Constants for the clock buffer power-up sequencer
package pwrup_seq_pkg;
    localparam int unsigned CLK_SYS_MHZ       = 100;
    // Settling delay window in microseconds
    localparam int unsigned SETTLE_MIN_US     = 200;
    localparam int unsigned SETTLE_MAX_US     = 300;
    // Total budget from power-on to outputs active, microseconds
    localparam int unsigned POWERUP_BUDGET_US = 1000;
    // Settling delay: least time of the window, an exact whole number of cycles
    localparam int unsigned SETTLE_CYCLES     = SETTLE_MIN_US * CLK_SYS_MHZ;
    localparam int unsigned BUDGET_CYCLES     = POWERUP_BUDGET_US * CLK_SYS_MHZ;
    // Clock detect window in system cycles, and edges needed in one window
    localparam int unsigned DETECT_WINDOW     = 64;
    localparam int unsigned DETECT_MIN_EDGES  = 4;
    localparam int unsigned NUM_PAIRS         = 12;

    typedef enum logic [1:0] {
        ST_OFF    = 2'h0,
        ST_SETTLE = 2'h1,
        ST_WAIT   = 2'h3,
        ST_ACTIVE = 2'h2
    } seq_state_t;
endpackage

// ### tb/buffer_powerup_output_gating_tb_top.sv
// Self-checking bench for the power-up output gating sequencer
`timescale 1ns/100ps
`default_nettype none
module buffer_powerup_output_gating_tb_top;
    localparam int unsigned SETTLE = 50;
    localparam int unsigned BUDGET = 500;
    localparam int unsigned NP     = pwrup_seq_pkg::NUM_PAIRS;
    logic          clk_sys = 1'b0, rstn = 1'b0, supply_detected = 1'b0, sleep_request = 1'b0;
    logic          reference_input = 1'b0, pll_locked = 1'b0, mirror_stable = 1'b0, bypass_mode = 1'b0;
    logic          ref_run = 1'b0, last_act = 1'b0;
    logic          outputs_active, budget_exceeded;
    logic [NP-1:0] oe_true_n, oe_comp_n;
    logic          notes[$];
    logic [2:0]    codes[8] = '{3'h0, 3'h1, 3'h0, 3'h2, 3'h0, 3'h4, 3'h0, 3'h7};
    logic [2:0]    m;
    int            fail_count = 0, checks_done = 0, waited = 0;

    buffer_powerup_output_gating #(.SETTLE_CYCLES(SETTLE), .BUDGET_CYCLES(BUDGET)) dut (
        .clk_sys(clk_sys), .rstn(rstn), .supply_detected(supply_detected), .sleep_request(sleep_request),
        .reference_input(reference_input), .pll_locked(pll_locked), .mirror_stable(mirror_stable),
        .bypass_mode(bypass_mode), .outputs_active(outputs_active), .budget_exceeded(budget_exceeded),
        .buffered_output_true_oe_n(oe_true_n), .buffered_output_complement_oe_n(oe_comp_n));

    initial forever #5 clk_sys = ~clk_sys;
    // Reference at an eighth of clk_sys, well under the sampling limit
    initial forever
    begin
        repeat (4) @(negedge clk_sys);
        reference_input = ref_run ? ~reference_input : 1'b0;
    end

    task automatic check_bit(input logic exp, input logic got);
        checks_done++;
        if (exp !== got)
        begin
            fail_count++;
            $display("unexpected at %0t: expected %0h got %0h", $time, exp, got);
        end
    endtask
    task automatic check_vec(input logic [NP-1:0] exp, input logic [NP-1:0] got);
        checks_done++;
        if (exp !== got)
        begin
            fail_count++;
            $display("unexpected at %0t: expected %0h got %0h", $time, exp, got);
        end
    endtask
    // Note the expected level, then wait a bounded time for the watcher to consume it
    task automatic expect_change(input logic exp, input int lim);
        notes.push_back(exp);
        waited = 0;
        while (notes.size() != 0 && waited < lim)
        begin
            @(negedge clk_sys);
            waited++;
        end
        check_bit(1'b0, logic'(notes.size() != 0));
        notes.delete();
    endtask
    task automatic hold(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    task automatic wrap_up;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Any change with no note pending is a spurious enable or disable
    always @(posedge clk_sys)
    begin
        #1;
        if (outputs_active !== last_act)
        begin
            last_act = outputs_active;
            check_bit(notes.size() != 0 ? notes.pop_front() : ~outputs_active, outputs_active);
            check_vec({NP{~outputs_active}}, oe_true_n);
            check_vec(oe_true_n, oe_comp_n);
        end
    end

    initial
    begin
        #200000;
        fail_count++;
        wrap_up();
    end

    initial
    begin
        void'($urandom(89847));
        hold(6);
        rstn = 1'b1;
        hold(3);
        ref_run = 1'b1;
        pll_locked = 1'b1;
        supply_detected = 1'b1;
        expect_change(1'b1, BUDGET);
        check_bit(1'b1, logic'(waited >= SETTLE && waited < BUDGET));
        check_bit(1'b0, budget_exceeded);
        $display("test power-up done");
        for (int i = 0; i < 4; i++)
        begin
            sleep_request = 1'b1;
            expect_change(1'b0, 3);
            hold($urandom_range(1, 20));
            sleep_request = 1'b0;
            expect_change(1'b1, 4);
        end
        $display("test sleep done");
        ref_run = 1'b0;
        expect_change(1'b0, 140);
        hold(200);
        ref_run = 1'b1;
        expect_change(1'b1, 140);
        $display("test clock loss done");
        for (int i = 0; i < 16; i++)
        begin
            m = i < 8 ? codes[i] : 3'($urandom_range(0, 7));
            {pll_locked, mirror_stable, bypass_mode} = m;
            if ((m != 3'h0) !== last_act)
                expect_change(m != 3'h0, 4);
            else
                hold(5);
        end
        {pll_locked, mirror_stable, bypass_mode} = 3'h4;
        if (!last_act)
            expect_change(1'b1, 4);
        $display("test enable sources done");
        supply_detected = 1'b0;
        expect_change(1'b0, 3);
        ref_run = 1'b0;
        hold(140);
        supply_detected = 1'b1;
        hold(BUDGET + 50);
        ref_run = 1'b1;
        expect_change(1'b1, 200);
        check_bit(1'b1, logic'(waited >= 4));
        check_bit(1'b0, budget_exceeded);
        $display("test no reference done");
        supply_detected = 1'b0;
        expect_change(1'b0, 3);
        {pll_locked, mirror_stable, bypass_mode} = 3'h0;
        supply_detected = 1'b1;
        hold(BUDGET + 10);
        check_bit(1'b1, budget_exceeded);
        pll_locked = 1'b1;
        expect_change(1'b1, 4);
        check_bit(1'b1, budget_exceeded);
        $display("test late lock done");
        wrap_up();
    end
endmodule
`default_nettype wire
